// [design/tmrcr_pkg.sv]
// Purpose: Shared constants for the auxiliary capture/reload timer.
// Assumes: Byte-wide special-function-register port, 200 MHz core clock.
// Notes: Tick ratios for the internal timebase are plain defaults.
package tmrcr_pkg;
   // Byte addresses on the special-function-register port.
   localparam logic [7:0] CTRL_ADDR = 8'hC8;
   localparam logic [7:0] HOLD_LO_ADDR = 8'hCA;
   localparam logic [7:0] HOLD_HI_ADDR = 8'hCB;
   localparam logic [7:0] CNT_LO_ADDR = 8'hCC;
   localparam logic [7:0] CNT_HI_ADDR = 8'hCD;
   // The control register is bit-addressable: bit n sits at this base plus n.
   localparam logic [7:0] CTRL_BIT_BASE = 8'hC8;
   localparam logic [7:0] CTRL_RESET = 8'h00;
   localparam logic [15:0] CNT_RESET = 16'h0000;
   localparam logic [15:0] CNT_ALL_ONES = 16'hFFFF;
   // Control field positions.
   localparam int BIT_ROLLOVER = 7;
   localparam int BIT_EXT_FLAG = 6;
   localparam int BIT_RX_BAUD = 5;
   localparam int BIT_TX_BAUD = 4;
   localparam int BIT_EXT_EN = 3;
   localparam int BIT_RUN = 2;
   localparam int BIT_CNT_SEL = 1;
   localparam int BIT_CAP_SEL = 0;
   // Core clocks per pin sample (one instruction cycle).
   localparam logic [1:0] SAMPLE_LAST = 2'h3;
   // Samples per slow timer tick when the prescale select is clear.
   localparam logic [1:0] SLOW_LAST = 2'h2;
endpackage : tmrcr_pkg

// [design/tmrcr_timer.sv]
// Purpose: 16-bit auxiliary timer/counter with capture, reload and baud modes.
// Assumes: Pins are synchronous to core_clk; interrupt enable lives outside.
// Notes: Hardware flag sets win over a software clear in the same cycle.
`timescale 1ns/10ps

// How it works
// - Rollover from FFFF sets the rollover flag; only software clears it.
// - No rollover flag while either baud-select bit is set.
// - Software writing one to the rollover flag raises the interrupt request.
// - Enabled trigger falling edge sets the edge flag outside baud mode; software set also requests.
// - Receive baud-select chooses this timer or other timer for receive timebase.
// - Transmit baud-select chooses this timer or other timer for transmit timebase.
// - Any baud-select set: count once every 2 clocks, ignoring counter select.
// - Edge enable clear ignores trigger; set and not baud: capture or reload.
// - Run bit starts counting; clear halts and keeps both count bytes unless an enabled trigger edge reloads them.
// - Counter select 0 counts prescaled ticks; 1 counts count-pin falling edges.
// - In baud mode capture select is ignored and every overflow reloads.
// - Reload mode: overflow loads high and low bytes from holding bytes.
// - Reload mode with edge enable: trigger edge reloads and sets edge flag.
// - Capture mode: trigger edge copies count into holding, sets edge flag.
// - Overflow in capture mode still sets the rollover flag.
// - A capture never stops or disturbs counting.
// - Control register is bit-addressable; single bits change alone.
module tmrcr_timer
   import tmrcr_pkg::*;
(
   // Clock and reset
   input wire logic core_clk,
   input wire logic rst,
   // Special-function-register byte port
   input wire logic [7:0] sfr_addr,
   input wire logic sfr_wr,
   input wire logic [7:0] sfr_wdata,
   output logic [7:0] sfr_rdata,
   // Single-bit write port
   input wire logic bit_wr,
   input wire logic [7:0] bit_addr,
   input wire logic bit_wdata,
   // Clock-control prescale bit
   input wire logic tick_prescale_select,
   // External pins
   input wire logic trigger_pin,
   input wire logic count_input_pin,
   // Serial timebase
   input wire logic other_timer_ovf,
   output logic rx_baud_tick,
   output logic tx_baud_tick,
   // Interrupt request towards the interrupt controller
   output logic timer_irq_req
);
   logic [7:0] ctrl;
   logic [15:0] count;
   logic [15:0] holding;
   logic [1:0] sample_cnt;
   logic [1:0] slow_cnt;
   logic half_tick;
   logic trig_now;
   logic trig_prev;
   logic cpin_now;
   logic cpin_prev;
   logic ovf_pulse;
   logic [7:0] next_ctrl;
   logic sample_en;
   logic slow_en;
   logic baud_mode;
   logic trig_fall;
   logic cpin_fall;
   logic inc_en;
   logic overflow;
   logic ext_event;
   logic do_reload;
   logic do_capture;
   logic ctrl_wr;
   logic ctrl_bit_wr;
   logic set_rollover;

   function automatic logic falling(input logic prev, input logic now);
      falling = prev & ~now;
   endfunction : falling

   assign sample_en = (sample_cnt == SAMPLE_LAST);
   assign slow_en = sample_en && (slow_cnt == SLOW_LAST);
   assign baud_mode = ctrl[BIT_RX_BAUD] | ctrl[BIT_TX_BAUD];
   // Edges are only looked at in the last slot of each sample period, once per new sample.
   assign trig_fall = sample_en & falling(trig_prev, trig_now);
   assign cpin_fall = sample_en & falling(cpin_prev, cpin_now);

   always_comb begin
      inc_en = 1'b0;
      if (ctrl[BIT_RUN]) begin
         if (baud_mode) begin
            inc_en = half_tick;
         end else if (ctrl[BIT_CNT_SEL]) begin
            inc_en = cpin_fall;
         end else begin
            inc_en = tick_prescale_select ? sample_en : slow_en;
         end
      end
   end

   assign overflow = inc_en && (count == CNT_ALL_ONES);
   assign ext_event = ctrl[BIT_EXT_EN] & ~baud_mode & trig_fall;
   assign do_capture = ext_event & ctrl[BIT_CAP_SEL];
   // Baud mode forces reload on every overflow, whatever the capture select.
   assign do_reload = (overflow & (baud_mode | ~ctrl[BIT_CAP_SEL]))
      | (ext_event & ~ctrl[BIT_CAP_SEL]);
   assign set_rollover = overflow & ~baud_mode;
   assign ctrl_wr = sfr_wr && (sfr_addr == CTRL_ADDR);
   assign ctrl_bit_wr = bit_wr && (bit_addr[7:3] == CTRL_BIT_BASE[7:3]);

   // Clock dividers: pin sample slot, slow tick and the half-rate baud tick.
   always_ff @(posedge core_clk or posedge rst) begin
      if (rst) begin
         sample_cnt <= 2'h0;
         slow_cnt <= 2'h0;
         half_tick <= 1'b0;
      end else begin
         sample_cnt <= sample_cnt + 2'h1;
         half_tick <= ~half_tick;
         if (sample_en) begin
            slow_cnt <= (slow_cnt == SLOW_LAST) ? 2'h0 : slow_cnt + 2'h1;
         end
      end
   end

   // Pin sampling, once per sample slot.
   always_ff @(posedge core_clk or posedge rst) begin
      if (rst) begin
         trig_now <= 1'b0;
         trig_prev <= 1'b0;
         cpin_now <= 1'b0;
         cpin_prev <= 1'b0;
      end else if (sample_cnt == 2'h0) begin
         trig_now <= trigger_pin;
         trig_prev <= trig_now;
         cpin_now <= count_input_pin;
         cpin_prev <= cpin_now;
      end
   end

   // Control register: byte writes, bit writes, then hardware sets on top.
   always_comb begin
      next_ctrl = ctrl;
      if (ctrl_wr) begin
         next_ctrl = sfr_wdata;
      end else if (ctrl_bit_wr) begin
         next_ctrl[bit_addr[2:0]] = bit_wdata;
      end
      // A set arriving with a software clear is not lost.
      if (set_rollover) begin
         next_ctrl[BIT_ROLLOVER] = 1'b1;
      end
      if (ext_event) begin
         next_ctrl[BIT_EXT_FLAG] = 1'b1;
      end
   end

   always_ff @(posedge core_clk or posedge rst) begin
      if (rst) begin
         ctrl <= CTRL_RESET;
      end else begin
         ctrl <= next_ctrl;
      end
   end

   // Count register. Software writes lose to reload and increment, which
   // keeps a free-running timer monotonic under late writes.
   always_ff @(posedge core_clk or posedge rst) begin
      if (rst) begin
         count <= CNT_RESET;
      end else if (do_reload) begin
         count <= holding;
      end else if (inc_en) begin
         count <= count + 16'h0001;
      end else if (sfr_wr && sfr_addr == CNT_LO_ADDR) begin
         count[7:0] <= sfr_wdata;
      end else if (sfr_wr && sfr_addr == CNT_HI_ADDR) begin
         count[15:8] <= sfr_wdata;
      end
   end

   // Holding register: a capture wins over a software write in the same cycle.
   always_ff @(posedge core_clk or posedge rst) begin
      if (rst) begin
         holding <= CNT_RESET;
      end else if (do_capture) begin
         holding <= count;
      end else if (sfr_wr && sfr_addr == HOLD_LO_ADDR) begin
         holding[7:0] <= sfr_wdata;
      end else if (sfr_wr && sfr_addr == HOLD_HI_ADDR) begin
         holding[15:8] <= sfr_wdata;
      end
   end

   // Read data is registered; unmapped addresses read zero.
   always_ff @(posedge core_clk or posedge rst) begin
      if (rst) begin
         sfr_rdata <= 8'h00;
      end else begin
         case (sfr_addr)
            CTRL_ADDR: sfr_rdata <= ctrl;
            HOLD_LO_ADDR: sfr_rdata <= holding[7:0];
            HOLD_HI_ADDR: sfr_rdata <= holding[15:8];
            CNT_LO_ADDR: sfr_rdata <= count[7:0];
            CNT_HI_ADDR: sfr_rdata <= count[15:8];
            default: sfr_rdata <= 8'h00;
         endcase
      end
   end

   // Baud timebase: this timer's overflow only when selected.
   always_ff @(posedge core_clk or posedge rst) begin
      if (rst) begin
         ovf_pulse <= 1'b0;
         rx_baud_tick <= 1'b0;
         tx_baud_tick <= 1'b0;
      end else begin
         ovf_pulse <= overflow;
         rx_baud_tick <= ctrl[BIT_RX_BAUD] ? overflow : other_timer_ovf;
         tx_baud_tick <= ctrl[BIT_TX_BAUD] ? overflow : other_timer_ovf;
      end
   end

   // Either flag, set by hardware or by software, requests the interrupt.
   assign timer_irq_req = ctrl[BIT_ROLLOVER] | ctrl[BIT_EXT_FLAG];

   property p_rollover_set;
      @(posedge core_clk) disable iff (rst)
         (overflow && !baud_mode) |=> ctrl[BIT_ROLLOVER] && timer_irq_req;
   endproperty
   a_rollover_set: assert property (p_rollover_set)
      else $error("rollover flag not set after overflow");

   property p_no_flag_baud;
      @(posedge core_clk) disable iff (rst)
         (baud_mode && !ctrl[BIT_ROLLOVER] && !ctrl_wr && !ctrl_bit_wr) |=>
            !ctrl[BIT_ROLLOVER];
   endproperty
   a_no_flag_baud: assert property (p_no_flag_baud)
      else $error("rollover flag set in baud mode");

   property p_sw_irq;
      @(posedge core_clk) disable iff (rst)
         (ctrl_wr && sfr_wdata[BIT_ROLLOVER]) |=> timer_irq_req;
   endproperty
   a_sw_irq: assert property (p_sw_irq)
      else $error("software set did not request interrupt");

   property p_edge_flag;
      @(posedge core_clk) disable iff (rst)
         ext_event |=> ctrl[BIT_EXT_FLAG];
   endproperty
   a_edge_flag: assert property (p_edge_flag)
      else $error("edge flag not set");

   property p_baud_rate;
      @(posedge core_clk) disable iff (rst)
         (ctrl[BIT_RUN] && baud_mode && !half_tick && !do_reload && !ctrl_wr &&
          !ctrl_bit_wr && !sfr_wr && count != CNT_ALL_ONES)
            |=> count == $past(count) ##1 count == $past(count) + 16'h0001;
   endproperty
   a_baud_rate: assert property (p_baud_rate)
      else $error("baud mode does not count every 2 clocks");

   property p_edge_ignored;
      @(posedge core_clk) disable iff (rst)
         !ctrl[BIT_EXT_EN] |-> !do_capture && !ext_event;
   endproperty
   a_edge_ignored: assert property (p_edge_ignored)
      else $error("trigger edge acted while disabled");

   property p_halt;
      @(posedge core_clk) disable iff (rst)
         (!ctrl[BIT_RUN] && !ext_event && !sfr_wr) |=> $stable(count);
   endproperty
   a_halt: assert property (p_halt)
      else $error("halted count changed");

   property p_reload;
      @(posedge core_clk) disable iff (rst)
         (overflow && (baud_mode || !ctrl[BIT_CAP_SEL])) |=> count == $past(holding);
   endproperty
   a_reload: assert property (p_reload)
      else $error("overflow did not reload");

   property p_capture;
      @(posedge core_clk) disable iff (rst)
         do_capture |=> holding == $past(count) && count != $past(holding) ||
            holding == $past(count);
   endproperty
   a_capture: assert property (p_capture)
      else $error("capture did not copy count");

   property p_baud_out;
      @(posedge core_clk) disable iff (rst)
         (ctrl[BIT_RX_BAUD] && overflow) |=> rx_baud_tick && ovf_pulse;
   endproperty
   a_baud_out: assert property (p_baud_out)
      else $error("receive baud tick missing");
endmodule : tmrcr_timer

// [test/tmrcr_pin_model.sv]
// Purpose: Drives the trigger and count pins of the auxiliary timer.
// Assumes: Pins are sampled once every 4 core clocks by the timer.
// Notes: Each pulse is 8 clocks high then 8 low, so no sample can miss it.
`timescale 1ns/10ps
module tmrcr_pin_model (
   // Clock
   input wire logic core_clk,
   // External pins
   output logic trigger_pin,
   output logic count_input_pin
);
   initial begin
      trigger_pin = 1'b0;
      count_input_pin = 1'b0;
   end
   // Holding each level for two sample periods keeps one edge per 8 clocks.
   task automatic fall_trigger();
      @(negedge core_clk) trigger_pin = 1'b1;
      repeat (8) @(negedge core_clk);
      trigger_pin = 1'b0;
      repeat (8) @(negedge core_clk);
   endtask : fall_trigger
   task automatic fall_count();
      @(negedge core_clk) count_input_pin = 1'b1;
      repeat (8) @(negedge core_clk);
      count_input_pin = 1'b0;
      repeat (8) @(negedge core_clk);
   endtask : fall_count
endmodule : tmrcr_pin_model

// [test/tb_timer2_capture_reload_counter.sv]
// Purpose: Self-checking bench for the auxiliary capture/reload timer.
// Assumes: Inputs change on the falling edge; read data lags the address by one cycle.
// Notes: Counts are written only while halted, since writes lose to increments.
`timescale 1ns/10ps
`define CHK(a, b) total_checks++; if ((a) !== (b)) begin n_fail++; \
   $display("ERROR %0t got %h expected %h", $time, (a), (b)); end
module tb_timer2_capture_reload_counter;
   import tmrcr_pkg::*;
   logic core_clk = 1'b0;
   logic rst = 1'b1;
   logic [7:0] sfr_addr = 8'h00;
   logic sfr_wr = 1'b0;
   logic [7:0] sfr_wdata = 8'h00;
   logic [7:0] sfr_rdata;
   logic bit_wr = 1'b0;
   logic [7:0] bit_addr = 8'h00;
   logic bit_wdata = 1'b0;
   logic tick_prescale_select = 1'b1;
   logic trigger_pin, count_input_pin;
   logic other_timer_ovf = 1'b0;
   logic rx_baud_tick, tx_baud_tick, timer_irq_req;
   int n_fail = 0;
   int total_checks = 0;
   logic [7:0] d, e;
   int n;
   always #2.5 core_clk = ~core_clk;
   tmrcr_timer i_dut (.core_clk(core_clk), .rst(rst), .sfr_addr(sfr_addr), .sfr_wr(sfr_wr),
      .sfr_wdata(sfr_wdata), .sfr_rdata(sfr_rdata), .bit_wr(bit_wr), .bit_addr(bit_addr),
      .bit_wdata(bit_wdata), .tick_prescale_select(tick_prescale_select),
      .trigger_pin(trigger_pin), .count_input_pin(count_input_pin),
      .other_timer_ovf(other_timer_ovf), .rx_baud_tick(rx_baud_tick),
      .tx_baud_tick(tx_baud_tick), .timer_irq_req(timer_irq_req));
   tmrcr_pin_model i_pins (.core_clk(core_clk), .trigger_pin(trigger_pin),
      .count_input_pin(count_input_pin));
   task automatic results();
      $display("checks %0d fails %0d", total_checks, n_fail);
      if (n_fail == 0 && total_checks > 0) $display("DONE - PASS");
      else $display("DONE - FAIL");
      $finish;
   endtask : results
   task automatic wr(input logic [7:0] a, input logic [7:0] v);
      @(negedge core_clk) begin
         sfr_addr = a;
         sfr_wdata = v;
         sfr_wr = 1'b1;
      end
      @(negedge core_clk) sfr_wr = 1'b0;
   endtask : wr
   task automatic bw(input int b, input logic v);
      @(negedge core_clk) begin
         bit_addr = CTRL_BIT_BASE + 8'(b);
         bit_wdata = v;
         bit_wr = 1'b1;
      end
      @(negedge core_clk) bit_wr = 1'b0;
   endtask : bw
   task automatic rd(input logic [7:0] a, output logic [7:0] v);
      @(negedge core_clk) sfr_addr = a;
      @(negedge core_clk) v = sfr_rdata;
   endtask : rd
   task automatic wait_bit(input int b);
      logic [7:0] v;
      for (int i = 0; i < 300; i++) begin
         rd(CTRL_ADDR, v);
         if (v[b] === 1'b1) return;
      end
      $display("ERROR %0t wait for control bit timed out", $time);
      n_fail++;
      results();
   endtask : wait_bit
   task automatic load(input logic [15:0] hold, input logic [15:0] cnt);
      wr(CTRL_ADDR, 8'h00);
      wr(HOLD_LO_ADDR, hold[7:0]);
      wr(HOLD_HI_ADDR, hold[15:8]);
      wr(CNT_LO_ADDR, cnt[7:0]);
      wr(CNT_HI_ADDR, cnt[15:8]);
   endtask : load
   initial begin
      repeat (2) @(negedge core_clk);
      rst = 1'b0;
      rd(CTRL_ADDR, d); `CHK(d, CTRL_RESET)
      rd(CNT_HI_ADDR, d); `CHK(d, CNT_RESET[15:8])
      rd(8'h00, d); `CHK(d, 8'h00)
      // Slow ticks: rollover from all ones sets the flag and reloads the count.
      tick_prescale_select = 1'b0;
      load(16'hFFF0, 16'hFFFE);
      bw(BIT_RUN, 1'b1);
      wait_bit(BIT_ROLLOVER);
      `CHK(timer_irq_req, 1'b1)
      bw(BIT_RUN, 1'b0);
      rd(CNT_HI_ADDR, d); `CHK(d, 8'hFF)
      rd(CNT_LO_ADDR, d); `CHK(d >= 8'hF0 && d < 8'hFE, 1'b1)
      repeat (30) @(negedge core_clk);
      rd(CNT_LO_ADDR, e); `CHK(e, d)
      rd(CTRL_ADDR, d); `CHK(d, 8'h80)
      bw(BIT_ROLLOVER, 1'b0);
      rd(CTRL_ADDR, d); `CHK(d, 8'h00)
      `CHK(timer_irq_req, 1'b0)
      bw(BIT_ROLLOVER, 1'b1);
      @(negedge core_clk); `CHK(timer_irq_req, 1'b1)
      bw(BIT_EXT_FLAG, 1'b1);
      bw(BIT_ROLLOVER, 1'b0);
      @(negedge core_clk); `CHK(timer_irq_req, 1'b1)
      tick_prescale_select = 1'b1;
      // Baud mode: one advance every 2 clocks, so one overflow every 4 clocks.
      // Capture select is set on purpose: only the forced reload keeps the ticks coming.
      load(16'hFFFE, 16'hFFFE);
      wr(CTRL_ADDR, 8'h37);
      n = 0;
      repeat (40) @(negedge core_clk) n += int'(rx_baud_tick);
      `CHK(n >= 9 && n <= 11, 1'b1)
      `CHK(n >= 9 && n <= 11, 1'b1)
      rd(CTRL_ADDR, d); `CHK(d, 8'h37)
      bw(BIT_TX_BAUD, 1'b0);
      @(negedge core_clk) other_timer_ovf = 1'b1;
      @(negedge core_clk) begin
         `CHK(tx_baud_tick, 1'b1)
         other_timer_ovf = 1'b0;
      end
      n = 0;
      repeat (40) @(negedge core_clk) n += int'(tx_baud_tick) + 2 * int'(rx_baud_tick);
      `CHK(n >= 18 && n <= 22, 1'b1)
      i_pins.fall_trigger();
      rd(CTRL_ADDR, d); `CHK(d, 8'h27)
      // Capture: holding takes the running count, counting goes on.
      load(16'h0000, 16'h0000);
      wr(CTRL_ADDR, 8'h0D);
      i_pins.fall_trigger();
      rd(CTRL_ADDR, d); `CHK(d, 8'h4D)
      rd(HOLD_LO_ADDR, d); `CHK(d != 8'h00, 1'b1)
      rd(CNT_LO_ADDR, e); `CHK(e > d, 1'b1)
      `CHK(timer_irq_req, 1'b1)
      load(16'h0000, 16'hFFFE);
      wr(CTRL_ADDR, 8'h0D);
      wait_bit(BIT_ROLLOVER);
      `CHK(timer_irq_req, 1'b1)
      // Edge enable clear ignores the trigger.
      wr(CTRL_ADDR, 8'h05);
      i_pins.fall_trigger();
      rd(CTRL_ADDR, d); `CHK(d[BIT_EXT_FLAG], 1'b0)
      // Reload mode with edge enable: the trigger reloads the count.
      load(16'h1234, 16'h0000);
      wr(CTRL_ADDR, 8'h0C);
      i_pins.fall_trigger();
      rd(CNT_HI_ADDR, d); `CHK(d, 8'h12)
      rd(CTRL_ADDR, d); `CHK(d, 8'h4C)
      // Counter mode counts only falling edges on the count pin.
      load(16'h0000, 16'h0000);
      wr(CTRL_ADDR, 8'h02);
      bw(BIT_RUN, 1'b1);
      repeat (3) i_pins.fall_count();
      rd(CNT_LO_ADDR, d); `CHK(d, 8'h03)
      rd(CTRL_ADDR, d); `CHK(d, 8'h06)
      results();
   end
endmodule : tb_timer2_capture_reload_counter
